// >>> pkg/radio_evt_pkg.sv
package radio_evt_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // task registers, write only
    localparam logic [11:0] OFF_SAMPLE_START = 12'h014;
    localparam logic [11:0] OFF_BC_START = 12'h01c;
    localparam logic [11:0] OFF_BC_STOP = 12'h020;

    // event flag registers, one per event index below
    localparam int NUM_EVT = 10;
    localparam logic [11:0] OFF_EVT [NUM_EVT] = '{
        12'h100, 12'h104, 12'h108, 12'h10c, 12'h110,
        12'h114, 12'h118, 12'h11c, 12'h128, 12'h130
    };

    // event indices, shared by flags, interrupt status and mask
    localparam int EVT_RAMPUP = 0;
    localparam int EVT_ADDRESS = 1;
    localparam int EVT_PAYLOAD = 2;
    localparam int EVT_PACKET = 3;
    localparam int EVT_OFF = 4;
    localparam int EVT_DEV_HIT = 5;
    localparam int EVT_DEV_MISS = 6;
    localparam int EVT_SAMPLE = 7;
    localparam int EVT_BC_HIT = 8;
    localparam int EVT_CRC_GOOD = 9;

    // value registers
    localparam logic [11:0] OFF_SAMPLE_VALUE = 12'h548;
    localparam logic [11:0] OFF_BC_COMPARE = 12'h560;

    // interrupt registers
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h700;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h704;

    // reset values
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [NUM_EVT-1:0] FLAG_RST = 10'h000;

    // default widths of counter and strength sample
    localparam int BC_W_DEF = 32;
    localparam int SAMPLE_W_DEF = 8;

    // strength measurement sequencer
    typedef enum logic {
        SAMPLE_IDLE,
        SAMPLE_BUSY
    } sample_state_t;

endpackage

// >>> hdl/event_flag_bank.sv
`timescale 1ns/1ps

module event_flag_bank #(
    parameter int N = radio_evt_pkg::NUM_EVT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // hardware set pulses and software writes
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] wr,
    input wire logic wr_val,
    // sticky flags
    output logic [N-1:0] flags
);

    typedef struct packed {
        logic [N-1:0] flags_r;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;

    // set beats a software write in the same cycle, so no event is lost
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < N; i++) begin
            if (set[i]) begin
                st_nxt.flags_r[i] = 1'b1;
            end else if (wr[i]) begin
                st_nxt.flags_r[i] = wr_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.flags_r <= radio_evt_pkg::FLAG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flags_r;

endmodule

// >>> hdl/radio_task_event_interface.sv
`timescale 1ns/1ps

// Summary of operation
// - write 1 at 0x01c starts bit counter
// - write 1 at 0x020 stops bit counter
// - ramp-up done sets flag 0x100
// - address sent or received sets 0x104
// - payload sent or received sets 0x108
// - whole packet done sets 0x10c
// - radio disabled sets flag 0x110
// - device address match sets 0x114
// - device address miss sets 0x118
// - strength sample stored, flag 0x11c set
// - counter equals compare value sets 0x128
// - good crc packet sets flag 0x130
// - strength start at 0x014 takes one sample
module radio_task_event_interface #(
    parameter int BC_W = radio_evt_pkg::BC_W_DEF,
    parameter int SAMPLE_W = radio_evt_pkg::SAMPLE_W_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [radio_evt_pkg::ADDR_W-1:0] paddr,
    input wire logic [radio_evt_pkg::DATA_W-1:0] pwdata,
    input wire logic [radio_evt_pkg::STRB_W-1:0] pstrb,
    output logic [radio_evt_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // event pulses from the radio core
    input wire logic rampup_done,
    input wire logic access_address,
    input wire logic payload_done,
    input wire logic packet_done,
    input wire logic radio_off,
    input wire logic device_hit,
    input wire logic device_miss,
    input wire logic crc_good,
    // bit timing and strength measurement from the core
    input wire logic bit_tick,
    input wire logic strength_valid,
    input wire logic [SAMPLE_W-1:0] received_signal_strength,
    // task pulses to the radio core
    output logic bit_counter_start,
    output logic bit_counter_stop,
    output logic strength_sample_start,
    // counter state and interrupt
    output logic [BC_W-1:0] bit_count,
    output logic irq
);

    localparam int N = radio_evt_pkg::NUM_EVT;

    typedef struct packed {
        logic [31:0] prdata_r;
        logic err_r;
        logic bc_start_r;
        logic bc_stop_r;
        logic sample_start_r;
        logic bc_run_r;
        logic [BC_W-1:0] bc_count_r;
        logic [BC_W-1:0] bc_cmp_r;
        logic [SAMPLE_W-1:0] sample_r;
        radio_evt_pkg::sample_state_t sample_st_r;
        logic [N-1:0] irq_status_r;
        logic [N-1:0] irq_mask_r;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;

    logic [N-1:0] flags;
    logic [N-1:0] evt_set;
    logic [N-1:0] evt_wr;
    logic [N-1:0] ext_evt;
    logic wr_fire;
    logic rd_setup;
    logic task_one;
    logic [BC_W-1:0] count_inc;
    logic bc_hit;
    logic sample_take;

    // one-hot match of an address against the event flag offsets
    function automatic logic [N-1:0] evt_decode(input logic [11:0] a);
        logic [N-1:0] hit;
        hit = '0;
        for (int i = 0; i < N; i++) begin
            hit[i] = (a == radio_evt_pkg::OFF_EVT[i]);
        end
        return hit;
    endfunction

    // every mapped offset, for the error answer
    function automatic logic addr_known(input logic [11:0] a);
        return (|evt_decode(a)) ||
            (a == radio_evt_pkg::OFF_SAMPLE_START) ||
            (a == radio_evt_pkg::OFF_BC_START) ||
            (a == radio_evt_pkg::OFF_BC_STOP) ||
            (a == radio_evt_pkg::OFF_SAMPLE_VALUE) ||
            (a == radio_evt_pkg::OFF_BC_COMPARE) ||
            (a == radio_evt_pkg::OFF_IRQ_STATUS) ||
            (a == radio_evt_pkg::OFF_IRQ_MASK);
    endfunction

    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign wr_fire = psel && penable && pwrite && addr_known(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    // a task fires only on a one in bit 0 with its byte lane enabled
    assign task_one = pwdata[0] && pstrb[0];

    // external events in flag order
    assign ext_evt = {crc_good, 1'b0, 1'b0, device_miss, device_hit,
        radio_off, packet_done, payload_done, access_address, rampup_done};

    // counter stepping and compare
    assign count_inc = st_r.bc_count_r + {{(BC_W-1){1'b0}}, 1'b1};
    assign bc_hit = st_r.bc_run_r && bit_tick && (count_inc == st_r.bc_cmp_r);
    // only the first valid after a start is taken
    assign sample_take = (st_r.sample_st_r == radio_evt_pkg::SAMPLE_BUSY) && strength_valid;

    // all hardware sets gathered
    always_comb begin
        evt_set = ext_evt;
        evt_set[radio_evt_pkg::EVT_SAMPLE] = sample_take;
        evt_set[radio_evt_pkg::EVT_BC_HIT] = bc_hit;
    end

    // software writes to flags; a write of 0 clears, a 1 sets
    assign evt_wr = evt_decode(paddr) & {N{wr_fire && pstrb[0]}};

    event_flag_bank #(
        .N(N)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(evt_set),
        .wr(evt_wr),
        .wr_val(pwdata[0]),
        .flags(flags)
    );

    // next state of tasks, counter, sampler, interrupts and read data
    always_comb begin
        st_nxt = st_r;
        // task pulses last a single cycle
        st_nxt.bc_start_r = 1'b0;
        st_nxt.bc_stop_r = 1'b0;
        st_nxt.sample_start_r = 1'b0;

        // bit counter advances on each on-air bit while running
        if (st_r.bc_run_r && bit_tick) begin
            st_nxt.bc_count_r = count_inc;
        end

        // one strength sample, then back to idle
        if (sample_take) begin
            st_nxt.sample_r = received_signal_strength;
            st_nxt.sample_st_r = radio_evt_pkg::SAMPLE_IDLE;
        end

        // interrupt status: set beats write-one-to-clear
        if (wr_fire && paddr == radio_evt_pkg::OFF_IRQ_STATUS) begin
            st_nxt.irq_status_r = st_r.irq_status_r & ~pwdata[N-1:0];
        end
        st_nxt.irq_status_r = st_nxt.irq_status_r | evt_set;

        // register writes take effect at the access edge
        if (wr_fire) begin
            unique case (paddr)
                radio_evt_pkg::OFF_BC_START: begin
                    if (task_one) begin
                        st_nxt.bc_start_r = 1'b1;
                        st_nxt.bc_run_r = 1'b1;
                        st_nxt.bc_count_r = '0;
                    end
                end
                radio_evt_pkg::OFF_BC_STOP: begin
                    if (task_one) begin
                        st_nxt.bc_stop_r = 1'b1;
                        st_nxt.bc_run_r = 1'b0;
                    end
                end
                radio_evt_pkg::OFF_SAMPLE_START: begin
                    if (task_one) begin
                        st_nxt.sample_start_r = 1'b1;
                        st_nxt.sample_st_r = radio_evt_pkg::SAMPLE_BUSY;
                    end
                end
                radio_evt_pkg::OFF_BC_COMPARE: begin
                    for (int b = 0; b < BC_W; b++) begin
                        if (pstrb[b/8]) begin
                            st_nxt.bc_cmp_r[b] = pwdata[b];
                        end
                    end
                end
                radio_evt_pkg::OFF_IRQ_MASK: begin
                    for (int b = 0; b < N; b++) begin
                        if (pstrb[b/8]) begin
                            st_nxt.irq_mask_r[b] = pwdata[b];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // read data captured in the setup cycle, so prdata is a flop
        if (rd_setup) begin
            st_nxt.prdata_r = '0;
            if (|evt_decode(paddr)) begin
                st_nxt.prdata_r[0] = |(evt_decode(paddr) & flags);
            end else if (paddr == radio_evt_pkg::OFF_SAMPLE_VALUE) begin
                st_nxt.prdata_r[SAMPLE_W-1:0] = st_r.sample_r;
            end else if (paddr == radio_evt_pkg::OFF_BC_COMPARE) begin
                st_nxt.prdata_r[BC_W-1:0] = st_r.bc_cmp_r;
            end else if (paddr == radio_evt_pkg::OFF_IRQ_STATUS) begin
                st_nxt.prdata_r[N-1:0] = st_r.irq_status_r;
            end else if (paddr == radio_evt_pkg::OFF_IRQ_MASK) begin
                st_nxt.prdata_r[N-1:0] = st_r.irq_mask_r;
            end
            // task registers are write only and read as zero
        end
        if (psel && !penable) begin
            st_nxt.err_r = !addr_known(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.prdata_r <= radio_evt_pkg::REG_RST;
            st_r.err_r <= 1'b0;
            st_r.bc_start_r <= 1'b0;
            st_r.bc_stop_r <= 1'b0;
            st_r.sample_start_r <= 1'b0;
            st_r.bc_run_r <= 1'b0;
            st_r.bc_count_r <= '0;
            st_r.bc_cmp_r <= '0;
            st_r.sample_r <= '0;
            st_r.sample_st_r <= radio_evt_pkg::SAMPLE_IDLE;
            st_r.irq_status_r <= radio_evt_pkg::FLAG_RST;
            st_r.irq_mask_r <= radio_evt_pkg::FLAG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign prdata = st_r.prdata_r;
    assign pslverr = psel && penable && st_r.err_r;
    assign bit_counter_start = st_r.bc_start_r;
    assign bit_counter_stop = st_r.bc_stop_r;
    assign strength_sample_start = st_r.sample_start_r;
    assign bit_count = st_r.bc_count_r;
    // level interrupt, high while any unmasked status bit stands
    assign irq = |(st_r.irq_status_r & st_r.irq_mask_r);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_bc_start;
    logic wr_bc_stop;
    logic wr_any_task;
    assign wr_bc_start = wr_fire && paddr == radio_evt_pkg::OFF_BC_START;
    assign wr_bc_stop = wr_fire && paddr == radio_evt_pkg::OFF_BC_STOP;
    assign wr_any_task = wr_bc_start || wr_bc_stop ||
        (wr_fire && paddr == radio_evt_pkg::OFF_SAMPLE_START);

    property p_bc_start;
        wr_bc_start && task_one |=> bit_counter_start && st_r.bc_run_r && bit_count == '0;
    endproperty
    a_bc_start: assert property (p_bc_start) else $error("start task did not run counter");

    property p_bc_stop;
        wr_bc_stop && task_one |=> bit_counter_stop && !st_r.bc_run_r;
    endproperty
    a_bc_stop: assert property (p_bc_stop) else $error("stop task did not halt counter");

    property p_ext_events;
        (|ext_evt) |=> ((flags & $past(ext_evt)) == $past(ext_evt));
    endproperty
    a_ext_events: assert property (p_ext_events) else $error("core event not latched");

    property p_sample;
        sample_take |=> flags[radio_evt_pkg::EVT_SAMPLE] &&
            st_r.sample_r == $past(received_signal_strength);
    endproperty
    a_sample: assert property (p_sample) else $error("strength sample not stored");

    property p_bc_hit;
        st_r.bc_run_r && bit_tick && (count_inc == st_r.bc_cmp_r)
            |=> flags[radio_evt_pkg::EVT_BC_HIT];
    endproperty
    a_bc_hit: assert property (p_bc_hit) else $error("compare match not flagged");

    property p_one_sample;
        (st_r.sample_st_r == radio_evt_pkg::SAMPLE_IDLE) && !strength_sample_start
            ##0 !(wr_fire && paddr == radio_evt_pkg::OFF_SAMPLE_START)
            |=> $stable(st_r.sample_r);
    endproperty
    a_one_sample: assert property (p_one_sample) else $error("extra strength sample taken");

    property p_flag_sticky;
        !(|evt_wr) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag dropped");

    property p_task_pulse;
        bit_counter_start || bit_counter_stop || strength_sample_start
            |=> !(bit_counter_start || bit_counter_stop || strength_sample_start) ||
            $past(wr_any_task);
    endproperty
    a_task_pulse: assert property (p_task_pulse) else $error("task pulse too long");

    property p_task_zero;
        wr_any_task && !task_one
            |=> !bit_counter_start && !bit_counter_stop && !strength_sample_start;
    endproperty
    a_task_zero: assert property (p_task_zero) else $error("zero write fired a task");

    // a plain zero write must clear; a same-cycle set is left to the set-wins path
    property p_flag_clear;
        (|evt_wr) && !pwdata[0] && !(|(evt_wr & evt_set)) |=> !(|(flags & $past(evt_wr)));
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("zero write left flag set");

    // a stopped counter holds its value until the next start
    property p_bc_hold;
        !st_r.bc_run_r && !wr_bc_start |=> $stable(bit_count);
    endproperty
    a_bc_hold: assert property (p_bc_hold) else $error("stopped counter moved");

    c_bc_start: cover property (bit_counter_start);
    c_bc_hit: cover property (bc_hit);
    c_sample: cover property (strength_sample_start ##[1:50] sample_take);
    c_irq: cover property ($rose(irq));
    c_set_clear: cover property (|(evt_set & evt_wr));

endmodule

// >>> testbench/radio_task_event_interface_tb.sv
`timescale 1ns/1ps

module radio_task_event_interface_tb;

    // clock, reset and apb
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] strb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // core side
    logic [9:0] ev = 10'h000;
    logic bit_tick = 1'b0;
    logic strength_valid = 1'b0;
    logic [7:0] rss = 8'h00;
    logic bc_start;
    logic bc_stop;
    logic ss_start;
    logic irq;
    logic [31:0] bit_count;
    // expected read words, bit 32 is the error response
    logic [32:0] rd_q[$];
    logic [11:0] tk[3] = '{12'h01c, 12'h020, 12'h014};
    int num_errors = 0;
    int comparisons = 0;
    int n;
    logic [7:0] v1;

    always #5 pclk = ~pclk;

    radio_task_event_interface i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rampup_done(ev[0]), .access_address(ev[1]),
        .payload_done(ev[2]), .packet_done(ev[3]), .radio_off(ev[4]), .device_hit(ev[5]),
        .device_miss(ev[6]), .crc_good(ev[9]), .bit_tick(bit_tick),
        .strength_valid(strength_valid), .received_signal_strength(rss),
        .bit_counter_start(bc_start), .bit_counter_stop(bc_stop),
        .strength_sample_start(ss_start), .bit_count(bit_count), .irq(irq)
    );

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic void chk(string nm, logic [32:0] exp, logic [32:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endfunction

    // read answers are taken at the edge that ends the access phase
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (rd_q.size() == 0) begin
                chk("unexpected read", 33'h0, 33'h1);
            end else begin
                chk("read word", rd_q.pop_front(), {pslverr, prdata});
            end
        end
    end

    // one apb transfer; the request stands until pready is seen high
    task automatic xfer(logic [11:0] a, logic w, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog may end a stuck wait
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] exp, logic err = 1'b0);
        rd_q.push_back({err, exp});
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic evp(int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask

    task automatic tick(int k);
        repeat (k) begin
            @(posedge pclk);
            bit_tick <= 1'b1;
        end
        @(posedge pclk);
        bit_tick <= 1'b0;
    endtask

    task automatic sv(logic [7:0] v);
        @(posedge pclk);
        rss <= v;
        strength_valid <= 1'b1;
        @(posedge pclk);
        strength_valid <= 1'b0;
    endtask

    // flag stays set after the pulse, irq follows status, both clear by software
    task automatic evchk(int i);
        logic [11:0] a;
        a = radio_evt_pkg::OFF_EVT[i];
        evp(i);
        repeat ($urandom_range(1, 4)) @(posedge pclk);
        #1;
        chk("irq raised", 33'h1, 33'(irq));
        rd(a, 32'h1);
        rd(radio_evt_pkg::OFF_IRQ_STATUS, 32'h1 << i);
        xfer(a, 1'b1, 32'h0);
        rd(a, 32'h0);
        xfer(radio_evt_pkg::OFF_IRQ_STATUS, 1'b1, 32'h1 << i);
        @(posedge pclk);
        #1;
        chk("irq cleared", 33'h0, 33'(irq));
    endtask

    // pulse must last exactly the cycle after the access edge
    task automatic tsk(int w, logic [31:0] d, logic exp);
        logic [2:0] e;
        e = exp ? (3'b001 << w) : 3'b000;
        xfer(tk[w], 1'b1, d);
        #1;
        chk("task pulse", 33'(e), 33'({ss_start, bc_stop, bc_start}));
        @(posedge pclk);
        #1;
        chk("task pulse end", 33'h0, 33'({ss_start, bc_stop, bc_start}));
    endtask

    initial begin
        #200000;
        num_errors++;
        end_sim();
    end

    initial begin
        void'($urandom(41));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, task words, unmapped slot refused
        for (int i = 0; i < 10; i++) rd(radio_evt_pkg::OFF_EVT[i], 32'h0);
        rd(12'h01c, 32'h0);
        rd(12'h020, 32'h0);
        xfer(12'h0f0, 1'b1, 32'hffff_ffff);
        rd(12'h0f0, 32'h0, 1'b1);
        rd(radio_evt_pkg::OFF_IRQ_STATUS, 32'h0);
        $display("test reset done");
        xfer(radio_evt_pkg::OFF_IRQ_MASK, 1'b1, 32'h3ff);
        for (int i = 0; i < 10; i++) if (i < 7 || i == 9) evchk(i);
        // masked event sets status only
        xfer(radio_evt_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
        evp(3);
        repeat (2) @(posedge pclk);
        #1;
        chk("masked irq", 33'h0, 33'(irq));
        rd(radio_evt_pkg::OFF_IRQ_STATUS, 32'h8);
        xfer(radio_evt_pkg::OFF_IRQ_STATUS, 1'b1, 32'h8);
        $display("test events done");
        // ones trigger, zeros and masked byte lanes do not
        for (int w = 0; w < 3; w++) begin
            tsk(w, 32'h1, 1'b1);
            tsk(w, 32'h0, 1'b0);
            tsk(w, 32'h2, 1'b0);
            strb = 4'he;
            tsk(w, 32'h1, 1'b0);
            strb = 4'hf;
        end
        $display("test tasks done");
        // compare hit lands on the n-th counted bit, not before
        n = 3 + $urandom_range(0, 5);
        xfer(radio_evt_pkg::OFF_BC_COMPARE, 1'b1, 32'(n));
        xfer(12'h01c, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        tick(n - 1);
        rd(12'h128, 32'h0);
        tick(1);
        rd(12'h128, 32'h1);
        #1;
        chk("bit count", 33'(n), 33'(bit_count));
        xfer(12'h020, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        tick(3);
        #1;
        chk("stopped count", 33'(n), 33'(bit_count));
        xfer(12'h01c, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        chk("restarted count", 33'h0, 33'(bit_count));
        $display("test bit counter done");
        // only the first sample after a start is kept
        v1 = 8'($urandom_range(0, 255));
        sv(~v1);
        xfer(12'h11c, 1'b1, 32'h0);
        sv(v1 ^ 8'h5a);
        rd(12'h11c, 32'h0);
        xfer(12'h014, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        sv(v1);
        sv(~v1);
        rd(12'h11c, 32'h1);
        rd(radio_evt_pkg::OFF_SAMPLE_VALUE, 32'(v1));
        $display("test strength done");
        // reset in mid-run clears a set flag
        evp(9);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h130, 32'h0);
        @(posedge pclk);
        chk("read notes left", 33'h0, 33'(rd_q.size()));
        $display("test second reset done");
        end_sim();
    end

endmodule
